/* hw/eid_detect.sv */
// External interrupt detector for two pins: noise canceller, trigger logic,
// captured level, sticky status with mask, AXI4-Lite register slave.
// Assumes pins are asynchronous to aclk; aclk is the gear clock.
// Functional notes
// R1 - Channel 3 trigger: 00 rising, 01 falling, 10 both edges, 11 reserved.
// R2 - Channel 4 uses same edge codes; 11 requests while filtered level high.
// R3 - Captured level reads 0 after reset or low, 1 when high.
// R4 - Captured level refreshed on every request, held between requests.
// R5 - High-speed interval: gear clock, or divided by 4, 8, 16.
// R6 - Low-speed mode samples at low-frequency clock divided by four.
// R7 - Control register bits 7 to 5 always read zero.
// R8 - Spurious requests on mode change or control rewrite are expected.
// R9 - Software disables interrupt before switching operating mode.
// R10 - Software disables interrupt before writing a control register.
// R11 - After high-to-low speed change, wait twelve periods, clear latch.
// R12 - After low-to-high speed change, wait two plus three intervals, clear.
// R13 - High speed: new level accepted after three equal samples.
// R14 - Low speed: new level accepted after two equal samples.
// R15 - Each trigger gives a one-cycle request pulse on the gear clock; channel 4 code 11 holds the request high while the level is high.
`timescale 1ns/1ps
module eid_detect
  import eid_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // External pins
  input wire logic ext_irq3_pin,
  input wire logic ext_irq4_pin,
  // Requests and interrupt
  output logic [1:0] irq_req,
  output logic irq,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [15:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [15:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0][2:0] hist;
    logic [1:0] filt;
    logic [1:0] filt_d;
    logic [1:0] req;
    logic [1:0] lvl;
    logic [1:0][1:0] tsel;
    logic [1:0][1:0] nsel;
    logic [1:0] status;
    logic [1:0] mask;
    logic low_speed;
    logic [3:0] pre;
    logic [7:0] lf_cnt;
    logic [1:0] lf_q;
    logic ls_tick;
    logic aw_hold;
    logic [15:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eid_state_type;

  eid_state_type state_ff;
  eid_state_type nxt_state;
  logic [1:0] sample_en;
  logic [1:0] trig;

  // ==========================================================
  // Per-channel sampling enable and trigger condition
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      always_comb begin
        if (state_ff.low_speed) begin
          sample_en[c] = state_ff.ls_tick; // see R6
        end else begin
          case (state_ff.nsel[c]) // see R5
            NC_DIV1: sample_en[c] = 1'b1;
            NC_DIV4: sample_en[c] = (state_ff.pre[1:0] == 2'h0);
            NC_DIV8: sample_en[c] = (state_ff.pre[2:0] == 3'h0);
            default: sample_en[c] = (state_ff.pre == 4'h0);
          endcase
        end
        case (state_ff.tsel[c]) // see R1 // see R2
          TRIG_RISE: trig[c] = state_ff.filt[c] & ~state_ff.filt_d[c];
          TRIG_FALL: trig[c] = ~state_ff.filt[c] & state_ff.filt_d[c];
          TRIG_BOTH: trig[c] = state_ff.filt[c] ^ state_ff.filt_d[c];
          default: trig[c] = (c == 1) ? state_ff.filt[c] : 1'b0;
        endcase
      end
    end
  endgenerate

  // ==========================================================
  // Next state
  logic have_aw;
  logic have_w;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [2:0] new_hist;
  logic [31:0] rd_val;
  logic rd_ok;

  assign awready = ~state_ff.aw_hold & ~state_ff.bvalid;
  assign wready = ~state_ff.w_hold & ~state_ff.bvalid;
  assign arready = ~state_ff.rvalid;

  always_comb begin
    nxt_state = state_ff;
    new_hist = 3'h0;
    nxt_state.sync1 = {ext_irq4_pin, ext_irq3_pin};
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.pre = state_ff.pre + 4'h1;
    // Low-frequency clock and its quarter
    nxt_state.ls_tick = 1'b0;
    if (state_ff.lf_cnt == LF_DIV - 8'h1) begin
      nxt_state.lf_cnt = 8'h0;
      nxt_state.lf_q = state_ff.lf_q + 2'h1;
      nxt_state.ls_tick = (state_ff.lf_q == LF_QUARTER); // see R6
    end else begin
      nxt_state.lf_cnt = state_ff.lf_cnt + 8'h1;
    end
    // Noise canceller
    for (int i = 0; i < 2; i++) begin
      if (sample_en[i]) begin
        new_hist = {state_ff.hist[i][1:0], state_ff.sync2[i]};
        nxt_state.hist[i] = new_hist;
        if (state_ff.low_speed) begin
          if (new_hist[1] == new_hist[0]) begin
            nxt_state.filt[i] = new_hist[0]; // see R14
          end
        end else if (new_hist == {3{new_hist[0]}}) begin
          nxt_state.filt[i] = new_hist[0]; // see R13
        end
      end
    end
    // Requests, captured level, sticky status
    nxt_state.filt_d = state_ff.filt;
    nxt_state.req = trig; // see R15
    for (int i = 0; i < 2; i++) begin
      if (trig[i]) begin
        nxt_state.lvl[i] = state_ff.filt[i]; // see R3 // see R4
      end
    end
    // Write channel capture
    have_aw = state_ff.aw_hold | (awvalid & awready);
    have_w = state_ff.w_hold | (wvalid & wready);
    wr_addr = state_ff.aw_hold ? state_ff.aw_addr : awaddr;
    wr_data = state_ff.w_hold ? state_ff.w_data : wdata;
    wr_strb = state_ff.w_hold ? state_ff.w_strb : wstrb;
    if (awvalid & awready) begin
      nxt_state.aw_hold = 1'b1;
      nxt_state.aw_addr = awaddr;
    end
    if (wvalid & wready) begin
      nxt_state.w_hold = 1'b1;
      nxt_state.w_data = wdata;
      nxt_state.w_strb = wstrb;
    end
    if (state_ff.bvalid & bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (have_aw & have_w & ~state_ff.bvalid) begin
      nxt_state.aw_hold = 1'b0;
      nxt_state.w_hold = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = RESP_OKAY;
      case (wr_addr)
        ADDR_CTRL3: if (wr_strb[0]) begin // see R8 // see R10
          nxt_state.tsel[0] = wr_data[TRIG_LSB +: 2];
          nxt_state.nsel[0] = wr_data[SEL_LSB +: 2];
        end
        ADDR_CTRL4: if (wr_strb[0]) begin
          nxt_state.tsel[1] = wr_data[TRIG_LSB +: 2];
          nxt_state.nsel[1] = wr_data[SEL_LSB +: 2];
        end
        ADDR_STATUS: if (wr_strb[0]) begin
          nxt_state.status = state_ff.status & ~wr_data[1:0];
        end
        ADDR_MASK: if (wr_strb[0]) begin
          nxt_state.mask = wr_data[1:0];
        end
        ADDR_MODE: if (wr_strb[0]) begin // see R9
          nxt_state.low_speed = wr_data[0];
        end
        default: nxt_state.bresp = RESP_SLVERR;
      endcase
    end
    // Set wins over clear
    nxt_state.status = nxt_state.status | trig;
    // Read channel
    rd_ok = 1'b1;
    case (araddr)
      ADDR_CTRL3: rd_val = {27'h0, state_ff.lvl[0], state_ff.tsel[0], state_ff.nsel[0]}; // see R7
      ADDR_CTRL4: rd_val = {27'h0, state_ff.lvl[1], state_ff.tsel[1], state_ff.nsel[1]}; // see R7
      ADDR_STATUS: rd_val = {30'h0, state_ff.status};
      ADDR_MASK: rd_val = {30'h0, state_ff.mask};
      ADDR_MODE: rd_val = {31'h0, state_ff.low_speed};
      default: begin
        rd_val = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
    if (state_ff.rvalid & rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (arvalid & arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = rd_val;
      nxt_state.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '0;
      state_ff.tsel[0] <= CTRL_RESET[TRIG_LSB +: 2];
      state_ff.tsel[1] <= CTRL_RESET[TRIG_LSB +: 2];
      state_ff.nsel[0] <= CTRL_RESET[SEL_LSB +: 2];
      state_ff.nsel[1] <= CTRL_RESET[SEL_LSB +: 2];
      state_ff.mask <= MASK_RESET;
      state_ff.low_speed <= MODE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs
  assign irq_req = state_ff.req;
  assign irq = |(state_ff.status & state_ff.mask);
  assign bvalid = state_ff.bvalid;
  assign bresp = state_ff.bresp;
  assign rvalid = state_ff.rvalid;
  assign rdata = state_ff.rdata;
  assign rresp = state_ff.rresp;

  // ==========================================================
  // Assertions
  a_ch3_rise_req: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
    (state_ff.tsel[0] == TRIG_RISE && state_ff.filt[0] && !state_ff.filt_d[0])
    |=> irq_req[0]) else $error("ch3 rising edge gave no request");
  a_ch3_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
    (state_ff.tsel[0] == TRIG_HIGH) |=> !irq_req[0])
    else $error("ch3 reserved code raised a request");
  a_ch4_high_req: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
    (state_ff.tsel[1] == TRIG_HIGH && state_ff.filt[1]) |=> irq_req[1])
    else $error("ch4 high level gave no request");
  a_level_capture: assert property (@(posedge aclk) disable iff (!aresetn) // see R3
    irq_req[0] |-> state_ff.lvl[0] == $past(state_ff.filt[0]))
    else $error("ch3 captured level wrong");
  a_level_hold: assert property (@(posedge aclk) disable iff (!aresetn) // see R4
    $changed(state_ff.lvl[1]) |-> irq_req[1])
    else $error("ch4 captured level changed without request");
  a_hs_div4: assert property (@(posedge aclk) disable iff (!aresetn) // see R5
    (sample_en[0] && !state_ff.low_speed && state_ff.nsel[0] == NC_DIV4)
    |=> !sample_en[0] [*3]) else $error("ch3 sampled too often at div 4");
  a_ls_sample: assert property (@(posedge aclk) disable iff (!aresetn) // see R6
    (state_ff.low_speed && sample_en[1]) |-> $past(state_ff.lf_q) == LF_QUARTER)
    else $error("low-speed sample not at quarter rate");
  a_ctrl_zero: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
    (arvalid && arready && (araddr == ADDR_CTRL3 || araddr == ADDR_CTRL4))
    |=> rdata[31:5] == 27'h0) else $error("control upper bits not zero");
  a_hs_three: assert property (@(posedge aclk) disable iff (!aresetn) // see R13
    ($changed(state_ff.filt[0]) && !$past(state_ff.low_speed))
    |-> state_ff.hist[0] == {3{state_ff.filt[0]}}) else $error("ch3 accepted before three");
  a_ls_two: assert property (@(posedge aclk) disable iff (!aresetn) // see R14
    ($changed(state_ff.filt[1]) && $past(state_ff.low_speed))
    |-> state_ff.hist[1][1:0] == {2{state_ff.filt[1]}}) else $error("ch4 accepted before two");
  a_req_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // see R15
    irq_req[0] |=> !irq_req[0]) else $error("ch3 request longer than one cycle");
endmodule : eid_detect

/* hw/eid_pkg.sv */
// Constants for the external interrupt edge and level detector (channels 3 and 4).
// Assumes an AXI4-Lite master with 32-bit data and a 16-bit byte address.
package eid_pkg;
  // ==========================================================
  // Register indices and byte addresses
  localparam logic [11:0] IDX_CTRL3 = 12'hfda;
  localparam logic [11:0] IDX_CTRL4 = 12'hfdb;
  localparam logic [11:0] IDX_STATUS = 12'hfdc;
  localparam logic [11:0] IDX_MASK = 12'hfdd;
  localparam logic [11:0] IDX_MODE = 12'hfde;
  localparam logic [15:0] ADDR_CTRL3 = {2'h0, IDX_CTRL3, 2'h0};
  localparam logic [15:0] ADDR_CTRL4 = {2'h0, IDX_CTRL4, 2'h0};
  localparam logic [15:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [15:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
  localparam logic [15:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
  // ==========================================================
  // Control register fields
  localparam int SEL_LSB = 0;
  localparam int TRIG_LSB = 2;
  localparam int LVL_POS = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic MODE_RESET = 1'h0;
  // ==========================================================
  // Trigger and interval codes
  localparam logic [1:0] TRIG_RISE = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_BOTH = 2'h2;
  localparam logic [1:0] TRIG_HIGH = 2'h3;
  localparam logic [1:0] NC_DIV1 = 2'h0;
  localparam logic [1:0] NC_DIV4 = 2'h1;
  localparam logic [1:0] NC_DIV8 = 2'h2;
  // ==========================================================
  // Timing: aclk is the gear clock, low-freq clock made by division
  localparam logic [7:0] LF_DIV = 8'h10;
  localparam logic [1:0] LF_QUARTER = 2'h3;
  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : eid_pkg

/* verif/eid_detect_bench.sv */
// Bench for the edge and level detector: AXI4-Lite master tasks and scenarios.
// Assumes the pin source model drives both pins.
`timescale 1ns/1ps
module eid_detect_bench;
  import eid_pkg::*;
  // ==========================================
  // Signals
  logic aclk = 1'b0, aresetn = 1'b0;
  logic ext_irq3_pin, ext_irq4_pin, irq;
  logic [1:0] irq_req, bresp, rresp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0] last_bresp = 2'h0;
  int n_errors = 0, n_tests = 0;
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  eid_pin_source eid_pin_source_inst (.aclk(aclk), .ext_irq3_pin(ext_irq3_pin),
    .ext_irq4_pin(ext_irq4_pin));
  eid_detect eid_detect_inst (.aclk(aclk), .aresetn(aresetn), .ext_irq3_pin(ext_irq3_pin),
    .ext_irq4_pin(ext_irq4_pin), .irq_req(irq_req), .irq(irq), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  // ==========================================
  // Common tasks
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic hang();
    n_errors++;
    $display("[FAIL] bus answer expected 1 seen 0");
    stop_test();
  endtask : hang
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        last_bresp = bresp;
        break;
      end
    end
    if (i == 40) hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    if (i == 40) hang();
  endtask : axi_rd
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, exp, d & m);
  endtask : rd_chk
  // Disable, rewrite control, clear spurious status, set mask
  task automatic cfg(input int ch, input logic [7:0] v, input logic [1:0] m);
    axi_wr(ADDR_MASK, 32'h0);
    axi_wr(ch ? ADDR_CTRL4 : ADDR_CTRL3, {24'h0, v});
    repeat (8) @(posedge aclk);
    axi_wr(ADDR_STATUS, 32'h3);
    axi_wr(ADDR_MASK, {30'h0, m});
  endtask : cfg
  task automatic watch(input int ch, input int n, output int first, output int cnt);
    first = -1;
    cnt = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (irq_req[ch] === 1'b1 && first < 0) first = i;
      if (irq_req[ch] === 1'b1) cnt++;
    end
  endtask : watch
  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("ctrl3_reset", ADDR_CTRL3, 32'hff, {24'h0, CTRL_RESET});
    rd_chk("ctrl4_reset", ADDR_CTRL4, 32'hff, {24'h0, CTRL_RESET});
    rd_chk("mask_reset", ADDR_MASK, 32'h3, {30'h0, MASK_RESET});
    axi_rd(16'h0100, d, r);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(16'h0100, 32'h0000_0000);
    chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, last_bresp});
    cfg(0, 8'hff, 2'h0);
    chk("mapped_bresp", {30'h0, RESP_OKAY}, {30'h0, last_bresp});
    rd_chk("ctrl3_write", ADDR_CTRL3, 32'hef, 32'h0f);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_edges(input int ch, input int ncodes);
    int first, cnt;
    for (int c = 0; c < ncodes; c++) begin
      cfg(ch, {4'h0, c[1:0], NC_DIV1}, 2'h3);
      eid_pin_source_inst.set_pin(ch, 1'b1);
      watch(ch, 20, first, cnt);
      chk("rise_req", c == 0 || c == 2, cnt);
      chk("rise_irq", c == 0 || c == 2, irq);
      if (cnt == 1) rd_chk("rise_lvl", ch ? ADDR_CTRL4 : ADDR_CTRL3, 32'h10, 32'h10);
      eid_pin_source_inst.set_pin(ch, 1'b0);
      watch(ch, 20, first, cnt);
      chk("fall_req", c == 1 || c == 2, cnt);
      if (c != 3) rd_chk("fall_lvl", ch ? ADDR_CTRL4 : ADDR_CTRL3, 32'h10,
        c ? 32'h0 : 32'h10);
    end
    $display("t_edges done");
  endtask : t_edges
  task automatic t_level();
    int first, cnt;
    cfg(1, {4'h0, TRIG_HIGH, NC_DIV1}, 2'h1);
    eid_pin_source_inst.set_pin(1, 1'b1);
    watch(1, 30, first, cnt);
    chk("level_run", 30 - first, cnt);
    chk("irq_masked", 0, irq);
    rd_chk("status4", ADDR_STATUS, 32'h3, 32'h2);
    axi_wr(ADDR_MASK, 32'h3);
    chk("irq_unmasked", 1, irq);
    eid_pin_source_inst.set_pin(1, 1'b0);
    watch(1, 12, first, cnt);
    watch(1, 20, first, cnt);
    chk("level_stop", 0, cnt);
    rd_chk("level_lvl", ADDR_CTRL4, 32'h10, 32'h10);
    axi_wr(ADDR_STATUS, 32'h3);
    chk("irq_cleared", 0, irq);
    $display("t_level done");
  endtask : t_level
  task automatic t_interval();
    int first, cnt, div;
    for (int k = 0; k < 4; k++) begin
      div = k ? (2 << k) : 1;
      cfg(0, {4'h0, TRIG_BOTH, k[1:0]}, 2'h0);
      eid_pin_source_inst.set_pin(0, !k[0]);
      watch(0, 70, first, cnt);
      chk("interval_lo", 1, first >= 2 * div + 1);
      chk("interval_hi", 1, first <= 3 * div + 8);
    end
    cfg(0, {4'h0, TRIG_BOTH, NC_DIV1}, 2'h0);
    eid_pin_source_inst.pulse_pin(0, 2);
    watch(0, 20, first, cnt);
    chk("glitch_req", 0, cnt);
    $display("t_interval done");
  endtask : t_interval
  task automatic t_slow();
    int first, cnt;
    axi_wr(ADDR_MASK, 32'h0);
    axi_wr(ADDR_MODE, 32'h1);
    repeat (12 * LF_DIV) @(posedge aclk);
    axi_wr(ADDR_STATUS, 32'h3);
    eid_pin_source_inst.set_pin(0, 1'b1);
    watch(0, 200, first, cnt);
    chk("slow_lo", 1, first >= 60);
    chk("slow_hi", 1, first <= 135);
    axi_wr(ADDR_MODE, 32'h0);
    repeat (2 + 3) @(posedge aclk);
    axi_wr(ADDR_STATUS, 32'h3);
    rd_chk("status_settled", ADDR_STATUS, 32'h3, 32'h0);
    $display("t_slow done");
  endtask : t_slow
  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_edges(0, 4);
    t_edges(1, 3);
    t_level();
    t_interval();
    t_slow();
    stop_test();
  end
endmodule : eid_detect_bench

/* verif/eid_pin_source.sv */
// Pin source model: drives the two external interrupt pins.
// Assumes callers enter its tasks just after a rising aclk edge.
`timescale 1ns/1ps
module eid_pin_source (
  // Clock
  input wire logic aclk,
  // Pins
  output logic ext_irq3_pin,
  output logic ext_irq4_pin
);
  // ==========================================
  // Pin drive
  initial begin
    ext_irq3_pin = 1'b0;
    ext_irq4_pin = 1'b0;
  end
  task automatic set_pin(input int ch, input logic lvl);
    if (ch == 0) ext_irq3_pin <= lvl;
    else ext_irq4_pin <= lvl;
  endtask : set_pin
  // Short high pulse, meant as noise
  task automatic pulse_pin(input int ch, input int len);
    set_pin(ch, 1'b1);
    repeat (len) @(posedge aclk);
    set_pin(ch, 1'b0);
  endtask : pulse_pin
endmodule : eid_pin_source
